/* File: hdl/pst_pkg.sv */
// pst_pkg: constants, command codes and carrier types of the status and
// telemetry bank.
// assumes: one 250 MHz clock; all users refer to names as pst_pkg::name.
package pst_pkg;

   // ************************************************************
   // command codes answered by the bank
   // ************************************************************
   localparam logic [7:0] CMD_CLEAR_FAULTS      = 8'h03;
   localparam logic [7:0] CMD_SUMMARY_BYTE      = 8'h78;
   localparam logic [7:0] CMD_SUMMARY_WORD      = 8'h79;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_ST = 8'h7a;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_ST = 8'h7b;
   localparam logic [7:0] CMD_INPUT_ST          = 8'h7c;
   localparam logic [7:0] CMD_TEMPERATURE_ST    = 8'h7d;
   localparam logic [7:0] CMD_COMM_LOGIC_ST     = 8'h7e;
   localparam logic [7:0] CMD_VENDOR_FAULT_ST   = 8'h80;
   localparam logic [7:0] CMD_INPUT_VOLTAGE_RD  = 8'h88;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_RD = 8'h8b;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_RD = 8'h8c;
   localparam logic [7:0] CMD_JUNCTION_TEMP_RD  = 8'h8d;
   localparam logic [7:0] CMD_DUTY_CYCLE_RD     = 8'h94;
   localparam logic [7:0] CMD_SWITCH_FREQ_RD    = 8'h95;
   localparam logic [7:0] CMD_PHASE_ONE_RD      = 8'h96;
   localparam logic [7:0] CMD_PHASE_TWO_RD      = 8'h97;

   // ************************************************************
   // reset values and field positions
   // ************************************************************
   localparam logic [7:0]  STATUS_RESET  = 8'h00;
   localparam logic [15:0] TELEM_RESET   = 16'h0000;
   localparam int          BIT_FAULT_HI  = 7;   // ov / oc / ot fault
   localparam int          BIT_WARN_HI   = 6;   // ov / oc-lv / ot warning
   localparam int          BIT_WARN_LO   = 5;   // uv / oc warn / ut warning
   localparam int          BIT_FAULT_LO  = 4;   // uv / uc / ut fault
   localparam int          CML_BAD_CMD   = 7;
   localparam int          CML_BAD_DATA  = 6;
   localparam int          CML_PEC       = 5;
   localparam int          CML_OTHER     = 1;
   localparam int          VEN_AUX_UV_WN = 5;
   localparam int          VEN_AUX_OV_WN = 4;
   localparam int          VEN_SYNC_LOST = 3;
   localparam int          VEN_AUX_UV_FT = 1;
   localparam int          VEN_AUX_OV_FT = 0;
   // warnings sit this many percent inside the fault limits
   localparam logic [16:0] AUX_WARN_DIV  = 17'd10;

   // telemetry slot indices
   localparam int TEL_VIN   = 0;
   localparam int TEL_VOUT  = 1;
   localparam int TEL_IOUT  = 2;
   localparam int TEL_TEMP  = 3;
   localparam int TEL_DUTY  = 4;
   localparam int TEL_FREQ  = 5;
   localparam int TEL_PH1   = 6;
   localparam int TEL_PH2   = 7;
   localparam int TEL_COUNT = 8;

   // ************************************************************
   // carrier types
   // ************************************************************
   typedef struct packed {
      logic       valid;             // one-cycle command strobe
      logic       write;             // 1: host writes, 0: host reads
      logic [7:0] code;              // command code
      logic       pec_error;         // packet error check failed
      logic       data_error;        // supported command, bad data
      logic       claimed_elsewhere; // another bank serves this code
   } pst_cmd_type;

   typedef struct packed {
      logic        valid;            // one-cycle answer strobe
      logic        two_bytes;        // 1: word read, 0: byte read
      logic [15:0] data;             // byte reads use bits 7:0
   } pst_rsp_type;

   // per status byte: {fault_hi, warn_hi, warn_lo, fault_lo} event pulses
   typedef struct packed {
      logic [3:0] vout;
      logic [3:0] iout;
      logic [3:0] vin;
      logic [3:0] temp;
      logic       sync_lost;
   } pst_fault_events_type;

   typedef struct packed {
      logic [7:0]              vout_st;
      logic [7:0]              iout_st;
      logic [7:0]              input_st;
      logic [7:0]              temp_st;
      logic [7:0]              cml_st;
      logic [7:0]              vendor_st;
      logic [TEL_COUNT-1:0][15:0] telem;
      pst_rsp_type             rsp;
      logic [15:0]             summary;
   } pst_state_type;

endpackage : pst_pkg

/* File: hdl/pst_bank.sv */
// pst_bank: latched status bytes, summary word and telemetry readings of a
// step-down power module, answered per command code.
// assumes: a bus protocol engine on the same clock decodes frames into
// one-cycle command strobes; monitors deliver one-cycle event pulses and
// sample strobes on the same clock.
//
// Behaviour
// [R01] output voltage byte: ov fault 7, ov warn 6, uv warn 5, uv fault 4.
// [R02] output current byte: oc 7, oc-low-voltage 6, oc warn 5, uc 4.
// [R03] input byte: ov fault 7, ov warn 6, uv warn 5, uv fault 4.
// [R04] temperature byte: ot fault 7, ot warn 6, ut warn 5, ut fault 4.
// [R05] comm byte bit 7 set on invalid or unsupported command code.
// [R06] comm byte bit 6 set on supported command with bad data.
// [R07] comm byte bit 5 set on packet error check failure.
// [R08] comm byte bit 1 set on write to read-only or other comm fault; the code sets it only on writes to mapped codes.
// [R09] vendor byte bit 3 set on loss of external clock sync.
// [R10] vendor bit 1 aux below low limit, bit 0 above high limit.
// [R11] vendor bits 5 and 4: aux warnings ten percent inside limits.
// [R12] status registers are single bytes, read-only, zero after reset.
// [R13] input voltage reading: two bytes, read-only, linear-11 volts.
// [R14] output voltage reading: two bytes, read-only, unsigned linear-16 volts.
// [R15] output current reading: two bytes, read-only, linear-11 amperes.
// [R16] junction temperature reading: two bytes, linear-11 degrees Celsius.
// [R17] duty cycle reading: two bytes, percent, measured while output enabled.
// [R18] frequency reading: two bytes, kilohertz, measured while output enabled.
// [R19] phase one current reading: two bytes, linear-11 amperes.
// [R20] phase two current reading: two bytes, linear-11 amperes.
// [R21] summary word low byte equals summary byte pointing at detail registers.
// [R22] status bits latch until clear-faults; bytes for status, words for telemetry.
// [R23] reserved and unused status bits read zero.
`timescale 1ns/100ps
`default_nettype none

module pst_bank
(
   input  wire logic                          clock,
   input  wire logic                          rst_n,
   // command port from the protocol engine
   input  wire pst_pkg::pst_cmd_type          cmd,
   output var  pst_pkg::pst_rsp_type          rsp,
   // fault and warning event pulses from the monitors
   input  wire pst_pkg::pst_fault_events_type events,
   input  wire logic                          busy_fault,
   input  wire logic                          unit_off,
   // aux voltage monitor sample and its programmed fault limits
   input  wire logic                          aux_sample_valid,
   input  wire logic [15:0]                   aux_voltage_monitor,
   input  wire logic [15:0]                   aux_monitor_low_limit,
   input  wire logic [15:0]                   aux_monitor_high_limit,
   // telemetry samples, already in their bus formats
   input  wire logic                          output_enabled,
   input  wire logic [pst_pkg::TEL_COUNT-1:0] telem_valid,
   input  wire logic [pst_pkg::TEL_COUNT-1:0][15:0] telem_data,
   // summary word, for the fault-status pin logic
   output var  logic [15:0]                   summary_word
);

   // ************************************************************
   // state
   // ************************************************************
   pst_pkg::pst_state_type state_reg;
   pst_pkg::pst_state_type state_next;

   // warning thresholds, one bit wider so the sums cannot wrap
   logic [16:0] aux_low_warn;
   logic [16:0] aux_high_warn;
   logic [16:0] aux_sample_w;
   logic        cmd_mapped;

   // ************************************************************
   // decoding
   // ************************************************************

   // true for every code this bank answers
   function automatic logic is_mapped(input logic [7:0] code);
      logic hit;
      hit = 1'b0;
      if (code == pst_pkg::CMD_SUMMARY_BYTE)
         hit = 1'b1;
      else if (code == pst_pkg::CMD_SUMMARY_WORD)
         hit = 1'b1;
      else if (code >= pst_pkg::CMD_OUTPUT_VOLTAGE_ST && code <= pst_pkg::CMD_COMM_LOGIC_ST)
         hit = 1'b1;
      else if (code == pst_pkg::CMD_VENDOR_FAULT_ST)
         hit = 1'b1;
      else if (code == pst_pkg::CMD_INPUT_VOLTAGE_RD)
         hit = 1'b1;
      else if (code >= pst_pkg::CMD_OUTPUT_VOLTAGE_RD && code <= pst_pkg::CMD_JUNCTION_TEMP_RD)
         hit = 1'b1;
      else if (code >= pst_pkg::CMD_DUTY_CYCLE_RD && code <= pst_pkg::CMD_PHASE_TWO_RD)
         hit = 1'b1;
      return hit;
   endfunction : is_mapped

   // answer of a read, from the current register contents
   function automatic pst_pkg::pst_rsp_type read_answer(input pst_pkg::pst_state_type s,
                                                       input logic [7:0] code);
      pst_pkg::pst_rsp_type r;
      r = '0;
      r.valid = 1'b1;
      // [R22] byte reads for status, a word read for the summary word
      if (code == pst_pkg::CMD_SUMMARY_BYTE)
         r.data = {8'h00, s.summary[7:0]};
      else if (code == pst_pkg::CMD_SUMMARY_WORD)
      begin
         r.two_bytes = 1'b1;
         r.data      = s.summary;
      end
      else if (code == pst_pkg::CMD_OUTPUT_VOLTAGE_ST)
         r.data = {8'h00, s.vout_st};
      else if (code == pst_pkg::CMD_OUTPUT_CURRENT_ST)
         r.data = {8'h00, s.iout_st};
      else if (code == pst_pkg::CMD_INPUT_ST)
         r.data = {8'h00, s.input_st};
      else if (code == pst_pkg::CMD_TEMPERATURE_ST)
         r.data = {8'h00, s.temp_st};
      else if (code == pst_pkg::CMD_COMM_LOGIC_ST)
         r.data = {8'h00, s.cml_st};
      else if (code == pst_pkg::CMD_VENDOR_FAULT_ST)
         r.data = {8'h00, s.vendor_st};
      else
      begin
         // [R13] [R14] [R15] [R16] word reads for telemetry
         r.two_bytes = 1'b1;
         if (code == pst_pkg::CMD_INPUT_VOLTAGE_RD)
            r.data = s.telem[pst_pkg::TEL_VIN];
         else if (code == pst_pkg::CMD_OUTPUT_VOLTAGE_RD)
            r.data = s.telem[pst_pkg::TEL_VOUT];
         else if (code == pst_pkg::CMD_OUTPUT_CURRENT_RD)
            r.data = s.telem[pst_pkg::TEL_IOUT];
         else if (code == pst_pkg::CMD_JUNCTION_TEMP_RD)
            r.data = s.telem[pst_pkg::TEL_TEMP];
         // [R17] [R18] duty and frequency words
         else if (code == pst_pkg::CMD_DUTY_CYCLE_RD)
            r.data = s.telem[pst_pkg::TEL_DUTY];
         else if (code == pst_pkg::CMD_SWITCH_FREQ_RD)
            r.data = s.telem[pst_pkg::TEL_FREQ];
         // [R19] [R20] per-phase currents
         else if (code == pst_pkg::CMD_PHASE_ONE_RD)
            r.data = s.telem[pst_pkg::TEL_PH1];
         else if (code == pst_pkg::CMD_PHASE_TWO_RD)
            r.data = s.telem[pst_pkg::TEL_PH2];
         else
         begin
            // unmapped: empty byte answer, comm fault is flagged elsewhere
            r.two_bytes = 1'b0;
            r.data      = 16'h0000;
         end
      end
      return r;
   endfunction : read_answer

   // ************************************************************
   // aux monitor thresholds
   // ************************************************************

   // [R11] warnings ten percent inside the limits; integer division
   // truncates, so a warning may trip one code later than its exact point
   assign aux_sample_w  = {1'b0, aux_voltage_monitor};
   assign aux_low_warn  = {1'b0, aux_monitor_low_limit}
                        + ({1'b0, aux_monitor_low_limit} / pst_pkg::AUX_WARN_DIV);
   assign aux_high_warn = {1'b0, aux_monitor_high_limit}
                        - ({1'b0, aux_monitor_high_limit} / pst_pkg::AUX_WARN_DIV);
   assign cmd_mapped    = is_mapped(cmd.code);

   // ************************************************************
   // next state
   // ************************************************************

   // the clear is applied first and events ORed in after it, so an event
   // in the clearing cycle survives
   always_comb
   begin
      logic clear;
      logic [7:0] ev_vout;
      logic [7:0] ev_iout;
      logic [7:0] ev_input;
      logic [7:0] ev_temp;
      logic [7:0] ev_cml;
      logic [7:0] ev_vendor;
      state_next = state_reg;
      clear      = cmd.valid && cmd.write && (cmd.code == pst_pkg::CMD_CLEAR_FAULTS)
                   && !cmd.pec_error;

      // [R01] output voltage fault and warning bits
      ev_vout  = {events.vout, 4'h0};
      // [R02] output current bits
      ev_iout  = {events.iout, 4'h0};
      // [R03] input bits
      ev_input = {events.vin, 4'h0};
      // [R04] temperature bits
      ev_temp  = {events.temp, 4'h0};

      ev_cml = 8'h00;
      if (cmd.valid)
      begin
         // [R05] unknown command code
         if (!cmd_mapped && !cmd.claimed_elsewhere && cmd.code != pst_pkg::CMD_CLEAR_FAULTS)
            ev_cml[pst_pkg::CML_BAD_CMD] = 1'b1;
         // [R06] bad data on a supported command
         if (cmd.data_error)
            ev_cml[pst_pkg::CML_BAD_DATA] = 1'b1;
         // [R07] packet error check failure
         if (cmd.pec_error)
            ev_cml[pst_pkg::CML_PEC] = 1'b1;
         // [R08] write to a read-only code
         if (cmd.write && cmd_mapped)
            ev_cml[pst_pkg::CML_OTHER] = 1'b1;
      end

      ev_vendor = 8'h00;
      // [R09] external clock sync lost
      ev_vendor[pst_pkg::VEN_SYNC_LOST] = events.sync_lost;
      if (aux_sample_valid)
      begin
         // [R10] aux fault limits
         ev_vendor[pst_pkg::VEN_AUX_UV_FT] = aux_voltage_monitor < aux_monitor_low_limit;
         ev_vendor[pst_pkg::VEN_AUX_OV_FT] = aux_voltage_monitor > aux_monitor_high_limit;
         // [R11] aux warning thresholds
         ev_vendor[pst_pkg::VEN_AUX_UV_WN] = aux_sample_w < aux_low_warn;
         ev_vendor[pst_pkg::VEN_AUX_OV_WN] = aux_sample_w > aux_high_warn;
      end

      // [R22] latch until clear-faults, set wins
      if (clear)
      begin
         state_next.vout_st   = pst_pkg::STATUS_RESET;
         state_next.iout_st   = pst_pkg::STATUS_RESET;
         state_next.input_st  = pst_pkg::STATUS_RESET;
         state_next.temp_st   = pst_pkg::STATUS_RESET;
         state_next.cml_st    = pst_pkg::STATUS_RESET;
         state_next.vendor_st = pst_pkg::STATUS_RESET;
      end
      // [R23] only defined bits can ever be set
      state_next.vout_st   = state_next.vout_st   | (ev_vout   & 8'hf0);
      state_next.iout_st   = state_next.iout_st   | (ev_iout   & 8'hf0);
      state_next.input_st  = state_next.input_st  | (ev_input  & 8'hf0);
      state_next.temp_st   = state_next.temp_st   | (ev_temp   & 8'hf0);
      state_next.cml_st    = state_next.cml_st    | (ev_cml    & 8'he2);
      state_next.vendor_st = state_next.vendor_st | (ev_vendor & 8'h3b);

      // [R13] [R14] [R15] [R16] [R19] [R20] telemetry refresh on sample strobe
      for (int i = 0; i < pst_pkg::TEL_COUNT; i++)
      begin
         // [R17] [R18] duty and frequency held while output is off
         if (telem_valid[i] && (output_enabled || (i != pst_pkg::TEL_DUTY && i != pst_pkg::TEL_FREQ)))
            state_next.telem[i] = telem_data[i];
      end

      // [R21] summary word from the latched detail bytes and the busy_fault and unit_off inputs
      state_next.summary[15] = |state_next.vout_st;
      state_next.summary[14] = |state_next.iout_st;
      state_next.summary[13] = |state_next.input_st;
      state_next.summary[12] = |state_next.vendor_st;
      state_next.summary[11:8] = 4'h0;
      state_next.summary[7]  = busy_fault;
      state_next.summary[6]  = unit_off;
      state_next.summary[5]  = state_next.vout_st[pst_pkg::BIT_FAULT_HI];
      state_next.summary[4]  = state_next.iout_st[pst_pkg::BIT_FAULT_HI];
      state_next.summary[3]  = state_next.input_st[pst_pkg::BIT_FAULT_LO];
      state_next.summary[2]  = |state_next.temp_st;
      state_next.summary[1]  = |state_next.cml_st;
      state_next.summary[0]  = 1'b0;

      // [R12] reads answer from the registers; writes get no answer
      state_next.rsp = '0;
      if (cmd.valid && !cmd.write)
         state_next.rsp = read_answer(state_reg, cmd.code);
   end

   // ************************************************************
   // registers
   // ************************************************************

   // [R12] all status bytes zero after reset
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_reg           <= '0;
         state_reg.vout_st   <= pst_pkg::STATUS_RESET;
         state_reg.iout_st   <= pst_pkg::STATUS_RESET;
         state_reg.input_st  <= pst_pkg::STATUS_RESET;
         state_reg.temp_st   <= pst_pkg::STATUS_RESET;
         state_reg.cml_st    <= pst_pkg::STATUS_RESET;
         state_reg.vendor_st <= pst_pkg::STATUS_RESET;
         state_reg.telem     <= {pst_pkg::TEL_COUNT{pst_pkg::TELEM_RESET}};
      end
      else
         state_reg <= state_next;
   end

   assign rsp          = state_reg.rsp;     // straight from flip-flops
   assign summary_word = state_reg.summary;

endmodule : pst_bank

`default_nettype wire

/* File: tb/pst_host_model.sv */
// pst_host_model: host side of the bank's command port, as the protocol
// engine presents decoded frames to it.
// assumes: shares the bank clock; the bench calls its tasks hierarchically.
`timescale 1ns/100ps
`default_nettype none

module pst_host_model
(
   input  wire logic                 clock,
   output var  pst_pkg::pst_cmd_type cmd,
   input  wire pst_pkg::pst_rsp_type rsp
);
   // ************************************************************
   // command strobes
   // ************************************************************
   initial cmd = '0;

   // one strobe: raised after an edge, dropped after the edge that takes it
   task automatic send(input logic wr, input logic [7:0] code, input logic pec,
                       input logic derr, input logic claim = 1'b0);
      @(posedge clock);
      cmd <= '{1'b1, wr, code, pec, derr, claim};
      @(posedge clock);
      cmd <= '0;
   endtask : send

   // byte or word read
   // answer is registered, so it is picked up just after the taking edge
   task automatic read(input logic [7:0] code, output pst_pkg::pst_rsp_type got);
      send(1'b0, code, 1'b0, 1'b0);
      #1;
      got = rsp;
   endtask : read
endmodule : pst_host_model
`default_nettype wire

/* File: tb/pst_bank_assertions.sv */
// pst_bank_assertions: timing checks on the bank's command, answer and
// summary ports.
// assumes: bound to every pst_bank; one clock, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module pst_chk
(
   input wire logic                          clock,
   input wire logic                          rst_n,
   input wire pst_pkg::pst_cmd_type          cmd,
   input wire pst_pkg::pst_rsp_type          rsp,
   input wire pst_pkg::pst_fault_events_type events,
   input wire logic                          busy_fault,
   input wire logic [15:0]                   summary_word
);
   // ************************************************************
   // properties
   // ************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   // a read is taken, then answered one cycle on
   sequence read_taken;
      cmd.valid && !cmd.write;
   endsequence
   sequence answer_seen;
      rsp.valid;
   endsequence

   a_read_answered : assert property (read_taken |=> answer_seen)
      else $error("read not answered after one cycle");
   a_write_silent : assert property (cmd.valid && cmd.write |=> !rsp.valid)
      else $error("write was answered");
   a_word_reading : assert property (read_taken ##0
      cmd.code == pst_pkg::CMD_INPUT_VOLTAGE_RD |=> rsp.two_bytes)
      else $error("reading not a word answer");
   a_byte_high_zero : assert property (rsp.valid && !rsp.two_bytes |->
      rsp.data[15:8] == 8'h00) else $error("byte answer upper half set");
   a_idle_quiet : assert property (!rsp.valid |-> rsp == '0)
      else $error("answer bus not idle");
   a_vout_flagged : assert property (events.vout[3] |=>
      summary_word[15] && summary_word[5]) else $error("vout fault not flagged");
   a_iout_flagged : assert property (events.iout[3] |=>
      summary_word[14] && summary_word[4]) else $error("iout fault not flagged");
   a_vin_flagged : assert property (events.vin[0] |=>
      summary_word[13] && summary_word[3]) else $error("vin fault not flagged");
   a_temp_flagged : assert property (|events.temp |=> summary_word[2])
      else $error("temperature not flagged");
   a_sync_flagged : assert property (events.sync_lost |=> summary_word[12])
      else $error("sync loss not flagged");
   a_busy_copied : assert property (busy_fault |=> summary_word[7])
      else $error("busy not copied");
   a_unused_zero : assert property (summary_word[11:8] == 4'h0 && !summary_word[0])
      else $error("unused summary bit set");
   a_latch_holds : assert property (summary_word[15] && !(cmd.valid && cmd.write
      && cmd.code == pst_pkg::CMD_CLEAR_FAULTS) |=> summary_word[15])
      else $error("latched status dropped");
endmodule : pst_chk

bind pst_bank pst_chk u_chk
(
   .clock        (clock),
   .rst_n        (rst_n),
   .cmd          (cmd),
   .rsp          (rsp),
   .events       (events),
   .busy_fault   (busy_fault),
   .summary_word (summary_word)
);
`default_nettype wire

/* File: tb/pst_bank_tb.sv */
// pst_bank_tb: self-checking bench of the status and telemetry bank.
// assumes: host model and checker compiled first; 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none

module pst_bank_tb;
   logic                                clock;
   logic                                rst_n;
   pst_pkg::pst_cmd_type                cmd;
   pst_pkg::pst_rsp_type                rsp;
   pst_pkg::pst_rsp_type                got;
   pst_pkg::pst_fault_events_type       events;
   logic                                busy_fault;
   logic                                unit_off;
   logic                                aux_sample_valid;
   logic [15:0]                         aux_voltage_monitor;
   logic [15:0]                         aux_monitor_low_limit;
   logic [15:0]                         aux_monitor_high_limit;
   logic                                output_enabled;
   logic [pst_pkg::TEL_COUNT-1:0]       telem_valid;
   logic [pst_pkg::TEL_COUNT-1:0][15:0] telem_data;
   logic [15:0]                         summary_word;
   int                                  fails;
   int                                  total_checks;
   logic [7:0]  st_codes [6] = '{8'h7a, 8'h7b, 8'h7c, 8'h7d, 8'h7e, 8'h80};
   logic [7:0]  tl_codes [8] = '{8'h88, 8'h8b, 8'h8c, 8'h8d, 8'h94, 8'h95, 8'h96, 8'h97};
   // limits 1000 and 5000: warnings below 1100 and above 4500
   logic [15:0] aux_in [6] = '{16'h01f4, 16'h157c, 16'h041a, 16'h1195, 16'h044c, 16'h1194};
   logic [7:0]  aux_exp [6] = '{8'h22, 8'h11, 8'h20, 8'h10, 8'h00, 8'h00};

   pst_host_model host (.clock(clock), .cmd(cmd), .rsp(rsp));

   pst_bank uut
   (
      .clock(clock), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .events(events),
      .busy_fault(busy_fault), .unit_off(unit_off), .aux_sample_valid(aux_sample_valid),
      .aux_voltage_monitor(aux_voltage_monitor),
      .aux_monitor_low_limit(aux_monitor_low_limit),
      .aux_monitor_high_limit(aux_monitor_high_limit), .output_enabled(output_enabled),
      .telem_valid(telem_valid), .telem_data(telem_data), .summary_word(summary_word)
   );

   // ************************************************************
   // helpers
   // ************************************************************
   always #2 clock = ~clock;

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // read and compare strobe, width flag and data of the answer
   task automatic expect_rd(input logic [7:0] code, input logic [15:0] exp, input logic two);
      host.read(code, got);
      check($sformatf("code %h flags", code), {got.valid, got.two_bytes}, {1'b1, two});
      check($sformatf("code %h data", code), got.data, exp);
   endtask : expect_rd

   task automatic fire(input pst_pkg::pst_fault_events_type e);
      @(posedge clock);
      events <= e;
      @(posedge clock);
      events <= '0;
   endtask : fire

   task automatic aux(input logic [15:0] v);
      @(posedge clock);
      aux_sample_valid    <= 1'b1;
      aux_voltage_monitor <= v;
      @(posedge clock);
      aux_sample_valid    <= 1'b0;
   endtask : aux

   // all eight slots strobed at once; enable decides whether duty and freq take
   task automatic load(input logic en, input logic [15:0] base);
      @(posedge clock);
      output_enabled <= en;
      telem_valid    <= 8'hff;
      for (int i = 0; i < 8; i++)
         telem_data[i] <= base + 16'(i);
      @(posedge clock);
      telem_valid    <= '0;
   endtask : load

   task automatic clear();
      host.send(1'b1, pst_pkg::CMD_CLEAR_FAULTS, 1'b0, 1'b0);
   endtask : clear

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish

   // ************************************************************
   // tests
   // ************************************************************
   // a hang would stall here long after the few hundred cycles needed
   initial
   begin
      #40000;
      fails++;
      tally_and_finish();
   end

   initial
   begin
      clock = 1'b0;
      rst_n = 1'b0;
      events = '0;
      {busy_fault, unit_off, aux_sample_valid, output_enabled} = 4'h0;
      aux_voltage_monitor = 16'h0bb8;
      aux_monitor_low_limit = 16'h03e8;
      aux_monitor_high_limit = 16'h1388;
      telem_valid = '0;
      telem_data = '0;
      fails = 0;
      total_checks = 0;
      repeat (16) @(posedge clock);
      rst_n <= 1'b1;
      foreach (st_codes[i]) expect_rd(st_codes[i], 16'h0000, 1'b0);
      expect_rd(8'h88, 16'h0000, 1'b1);
      // each of the sixteen status-byte event bits alone: lands in its position, then stays until cleared
      for (int b = 0; b < 16; b++)
      begin
         fire(pst_pkg::pst_fault_events_type'(17'h1_0000 >> b));
         expect_rd(st_codes[b / 4], 16'h0080 >> (b % 4), 1'b0);
         expect_rd(st_codes[b / 4], 16'h0080 >> (b % 4), 1'b0);
         clear();
      end
      busy_fault <= 1'b1;
      unit_off <= 1'b1;
      fire(pst_pkg::pst_fault_events_type'(17'h1_0000));
      expect_rd(8'h79, 16'h80e0, 1'b1);
      check("summary word", summary_word, 16'h80e0);
      expect_rd(8'h78, 16'h00e0, 1'b0);
      busy_fault <= 1'b0;
      unit_off <= 1'b0;
      host.send(1'b1, pst_pkg::CMD_CLEAR_FAULTS, 1'b1, 1'b0);
      expect_rd(8'h7a, 16'h0080, 1'b0);
      expect_rd(8'h7e, 16'h0020, 1'b0);
      clear();
      expect_rd(8'h79, 16'h0000, 1'b1);
      expect_rd(8'h55, 16'h0000, 1'b0);
      host.send(1'b1, 8'h7a, 1'b0, 1'b0);
      host.send(1'b0, 8'h7c, 1'b0, 1'b1);
      host.send(1'b0, 8'h7b, 1'b1, 1'b0);
      expect_rd(8'h7a, 16'h0000, 1'b0);
      expect_rd(8'h7e, 16'h00e2, 1'b0);
      clear();
      // a code owned by another bank is not flagged here
      host.send(1'b0, 8'h56, 1'b0, 1'b0, 1'b1);
      expect_rd(8'h7e, 16'h0000, 1'b0);
      fire(pst_pkg::pst_fault_events_type'(17'h0_0001));
      expect_rd(8'h80, 16'h0008, 1'b0);
      clear();
      foreach (aux_in[i])
      begin
         aux(aux_in[i]);
         expect_rd(8'h80, {8'h00, aux_exp[i]}, 1'b0);
         clear();
      end
      load(1'b1, 16'h1100);
      load(1'b0, 16'h2200);
      foreach (tl_codes[i])
         expect_rd(tl_codes[i], ((i == 4 || i == 5) ? 16'h1100 : 16'h2200) + 16'(i), 1'b1);
      host.send(1'b1, 8'h8b, 1'b0, 1'b0);
      expect_rd(8'h8b, 16'h2201, 1'b1);
      // second reset in mid-run wipes the latched write refusal
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      expect_rd(8'h7e, 16'h0000, 1'b0);
      tally_and_finish();
   end
endmodule : pst_bank_tb
`default_nettype wire
